// [verilog/control_flow_priority_pkg.sv]
// What this block does
// - Near call pushes PC high then low below SP, jumps, SP minus two, 12 clocks.
// - Relative branch adds signed displacement, always or on condition, in 5 clocks.
// - Far call pushes page, PC high, PC low; loads page and target; SP minus three; 19.
// - Far return pops PC low, PC high, page; SP plus three; 13 clocks.
// - Near return pops PC low then high, SP plus two; conditional form 8 or 2.
// - Interrupt return pops priority, then PC low and high; SP plus three; 12 clocks.
// - Push level shifts priority left two, operand into bits 1,0, in 4 clocks.
// - Pop level rotates priority right two bits, restoring the saved level.
// - Priority pop from stack is 7 clocks SP plus one; push is 9 clocks SP minus one.
// - Legacy acknowledge pushes PC high then low, SP minus two, updates priority, 10 clocks.
// - After a privileged instruction no interrupt before the next instruction executes.
// - Loading SP from HL, IX or IY is privileged.
// - Push level, pop level and priority pop from stack are privileged.
// - Writing the code page from the accumulator is privileged.
// - Bit test of the byte at HL is privileged.
// - Bit set leaves all condition flags unchanged.
// - Page write then interrupt return forms an uninterruptible far transfer.
// - Restart vectors from the external vector base; values 00, 08 and 30h are refused.
package control_flow_priority_pkg;
  typedef enum logic [4:0] {
    OP_CALL, OP_JR, OP_JR_CC, OP_DEC_BRANCH, OP_JP_HL, OP_JP_IX, OP_JP_IY, OP_JP, OP_JP_F,
    OP_FAR_CALL, OP_FAR_JUMP, OP_FAR_RET, OP_RET, OP_RET_F, OP_INT_RET, OP_RESTART,
    OP_PUSH_LEVEL, OP_POP_LEVEL, OP_POP_PSR, OP_PUSH_PSR, OP_LEGACY_ACK,
    OP_LD_SP_HL, OP_LD_SP_IX, OP_LD_SP_IY, OP_LD_PAGE, OP_BIT_HL, OP_SET_BIT, OP_OTHER
  } op_t;
  localparam logic [4:0] CLK_CALL = 5'h0c;
  localparam logic [4:0] CLK_JR = 5'h05;
  localparam logic [4:0] CLK_JP_HL = 5'h04;
  localparam logic [4:0] CLK_JP_INDEX = 5'h06;
  localparam logic [4:0] CLK_JP = 5'h07;
  localparam logic [4:0] CLK_FAR_CALL = 5'h13;
  localparam logic [4:0] CLK_FAR_JUMP = 5'h0a;
  localparam logic [4:0] CLK_FAR_RET = 5'h0d;
  localparam logic [4:0] CLK_RET = 5'h08;
  localparam logic [4:0] CLK_RET_SKIP = 5'h02;
  localparam logic [4:0] CLK_INT_RET = 5'h0c;
  localparam logic [4:0] CLK_RESTART = 5'h0a;
  localparam logic [4:0] CLK_LEVEL = 5'h04;
  localparam logic [4:0] CLK_POP_PSR = 5'h07;
  localparam logic [4:0] CLK_PUSH_PSR = 5'h09;
  localparam logic [4:0] CLK_LEGACY = 5'h0a;
  localparam logic [4:0] CLK_LD_SP = 5'h02;
  localparam logic [4:0] CLK_LD_PAGE = 5'h04;
  localparam logic [4:0] CLK_BIT_HL = 5'h07;
  localparam logic [4:0] CLK_SET_BIT = 5'h0a;
  localparam logic [4:0] CLK_OTHER = 5'h02;
  localparam logic [1:0] LEGACY_LEVEL = 2'h1;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'hff;
  localparam logic [1:0] SEL_PCL = 2'h0;
  localparam logic [1:0] SEL_PCH = 2'h1;
  localparam logic [1:0] SEL_PAGE = 2'h2;
  localparam logic [1:0] SEL_PRIO = 2'h3;
endpackage : control_flow_priority_pkg

// [verilog/control_flow_priority_exec.sv]
module control_flow_priority_exec (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire control_flow_priority_pkg::op_t op_i,
  input wire logic cond_i,
  input wire logic [15:0] next_pc_i,
  input wire logic [15:0] imm_i,
  input wire logic [7:0] disp_i,
  input wire logic [7:0] page_i,
  input wire logic [1:0] level_i,
  input wire logic [7:0] vec_i,
  input wire logic [7:0] ext_base_i,
  input wire logic [15:0] hl_i,
  input wire logic [15:0] ix_i,
  input wire logic [15:0] iy_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic alt_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] pc_o,
  output logic [15:0] sp_o,
  output logic [7:0] page_o,
  output logic [7:0] prio_o,
  output logic [7:0] b_o,
  output logic b_we_o,
  output logic b_alt_o,
  output logic flags_we_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic int_ok_o
);
  import control_flow_priority_pkg::*;

  function automatic logic [4:0] clocks(input op_t op, input logic take);
    case (op)
      OP_CALL: clocks = CLK_CALL;
      OP_JR, OP_JR_CC, OP_DEC_BRANCH: clocks = CLK_JR;
      OP_JP_HL: clocks = CLK_JP_HL;
      OP_JP_IX, OP_JP_IY: clocks = CLK_JP_INDEX;
      OP_JP, OP_JP_F: clocks = CLK_JP;
      OP_FAR_CALL: clocks = CLK_FAR_CALL;
      OP_FAR_JUMP: clocks = CLK_FAR_JUMP;
      OP_FAR_RET: clocks = CLK_FAR_RET;
      OP_RET: clocks = CLK_RET;
      OP_RET_F: clocks = take ? CLK_RET : CLK_RET_SKIP;
      OP_INT_RET: clocks = CLK_INT_RET;
      OP_RESTART: clocks = CLK_RESTART;
      OP_PUSH_LEVEL, OP_POP_LEVEL: clocks = CLK_LEVEL;
      OP_POP_PSR: clocks = CLK_POP_PSR;
      OP_PUSH_PSR: clocks = CLK_PUSH_PSR;
      OP_LEGACY_ACK: clocks = CLK_LEGACY;
      OP_LD_SP_HL, OP_LD_SP_IX, OP_LD_SP_IY: clocks = CLK_LD_SP;
      OP_LD_PAGE: clocks = CLK_LD_PAGE;
      OP_BIT_HL: clocks = CLK_BIT_HL;
      OP_SET_BIT: clocks = CLK_SET_BIT;
      default: clocks = CLK_OTHER;
    endcase
  endfunction : clocks

  // Number of stack bytes moved; the direction follows from is_push.
  function automatic logic [1:0] stack_bytes(input op_t op, input logic take);
    case (op)
      OP_CALL, OP_RESTART, OP_LEGACY_ACK, OP_RET: stack_bytes = 2'h2;
      OP_RET_F: stack_bytes = take ? 2'h2 : 2'h0;
      OP_FAR_CALL, OP_FAR_RET, OP_INT_RET: stack_bytes = 2'h3;
      OP_POP_PSR, OP_PUSH_PSR: stack_bytes = 2'h1;
      default: stack_bytes = 2'h0;
    endcase
  endfunction : stack_bytes

  function automatic logic is_push(input op_t op);
    is_push = (op == OP_CALL) || (op == OP_RESTART) || (op == OP_LEGACY_ACK) ||
      (op == OP_FAR_CALL) || (op == OP_PUSH_PSR);
  endfunction : is_push

  // Which byte a stack step carries, in stack order.
  function automatic logic [1:0] byte_sel(input op_t op, input logic [1:0] step);
    case (op)
      OP_FAR_CALL: byte_sel = (step == 2'h0) ? SEL_PAGE : ((step == 2'h1) ? SEL_PCH : SEL_PCL);
      OP_CALL, OP_RESTART, OP_LEGACY_ACK: byte_sel = (step == 2'h0) ? SEL_PCH : SEL_PCL;
      OP_INT_RET: byte_sel = (step == 2'h0) ? SEL_PRIO : ((step == 2'h1) ? SEL_PCL : SEL_PCH);
      OP_PUSH_PSR, OP_POP_PSR: byte_sel = SEL_PRIO;
      default: byte_sel = (step == 2'h0) ? SEL_PCL : ((step == 2'h1) ? SEL_PCH : SEL_PAGE);
    endcase
  endfunction : byte_sel

  function automatic logic is_priv(input op_t op);
    is_priv = (op == OP_LD_SP_HL) || (op == OP_LD_SP_IX) || (op == OP_LD_SP_IY) ||
      (op == OP_PUSH_LEVEL) || (op == OP_POP_LEVEL) || (op == OP_POP_PSR) ||
      (op == OP_LD_PAGE) ||
      (op == OP_BIT_HL);
  endfunction : is_priv

  logic busy;
  logic [4:0] cnt;
  logic [4:0] n_clk;
  op_t op;
  logic take;
  logic priv;
  logic cap;
  logic [1:0] cap_sel;
  logic [1:0] req_sel;
  logic [7:0] rb [4];

  wire logic vec_ok = (vec_i == 8'h10) || (vec_i == 8'h18) || (vec_i == 8'h20) ||
    (vec_i == 8'h28) || (vec_i == 8'h38);
  wire logic bad = (op_i == OP_RESTART) && !vec_ok;
  wire logic go = start_i && !busy && !bad;
  wire logic [7:0] b_dec = b_i - 8'h01;
  wire logic next_take = (op_i == OP_DEC_BRANCH) ? (b_dec != 8'h00) :
    ((op_i == OP_JR_CC) || (op_i == OP_JP_F) || (op_i == OP_RET_F)) ? cond_i : 1'b1;
  wire logic fin = busy && (cnt == n_clk - 5'h01);
  wire logic [1:0] step = 2'(cnt - 5'h01);
  wire logic issue = busy && (cnt != 5'h00) && (cnt <= {3'h0, stack_bytes(op, take)});
  wire logic [1:0] sel = byte_sel(op, step);
  wire logic [15:0] next_addr = is_push(op) ? sp_o - 16'h0001 - {14'h0, step} : sp_o + {14'h0, step};
  wire logic [7:0] next_wdata = (sel == SEL_PCL) ? next_pc_i[7:0] :
    (sel == SEL_PCH) ? next_pc_i[15:8] : (sel == SEL_PAGE) ? page_o : prio_o;
  wire logic [15:0] rel_pc = next_pc_i + {{8{disp_i[7]}}, disp_i};
  wire logic [15:0] popped_pc = {rb[SEL_PCH], rb[SEL_PCL]};

  function automatic logic [15:0] commit_pc(input op_t o, input logic t);
    case (o)
      OP_CALL, OP_JP, OP_FAR_CALL, OP_FAR_JUMP: commit_pc = imm_i;
      OP_JP_F: commit_pc = t ? imm_i : next_pc_i;
      OP_JR, OP_JR_CC, OP_DEC_BRANCH: commit_pc = t ? rel_pc : next_pc_i;
      OP_JP_HL: commit_pc = hl_i;
      OP_JP_IX: commit_pc = ix_i;
      OP_JP_IY: commit_pc = iy_i;
      OP_FAR_RET, OP_RET, OP_INT_RET: commit_pc = popped_pc;
      OP_RET_F: commit_pc = t ? popped_pc : next_pc_i;
      OP_RESTART: commit_pc = {ext_base_i, vec_i};
      default: commit_pc = next_pc_i;
    endcase
  endfunction : commit_pc

  function automatic logic [15:0] commit_sp(input op_t o, input logic t);
    case (o)
      OP_CALL, OP_RESTART, OP_LEGACY_ACK: commit_sp = sp_o - 16'h0002;
      OP_FAR_CALL: commit_sp = sp_o - 16'h0003;
      OP_FAR_RET, OP_INT_RET: commit_sp = sp_o + 16'h0003;
      OP_RET: commit_sp = sp_o + 16'h0002;
      OP_RET_F: commit_sp = t ? sp_o + 16'h0002 : sp_o;
      OP_POP_PSR: commit_sp = sp_o + 16'h0001;
      OP_PUSH_PSR: commit_sp = sp_o - 16'h0001;
      OP_LD_SP_HL: commit_sp = hl_i;
      OP_LD_SP_IX: commit_sp = ix_i;
      OP_LD_SP_IY: commit_sp = iy_i;
      default: commit_sp = sp_o;
    endcase
  endfunction : commit_sp

  wire logic [7:0] next_page = ((op == OP_FAR_CALL) || (op == OP_FAR_JUMP)) ? page_i :
    (op == OP_FAR_RET) ? rb[SEL_PAGE] : (op == OP_LD_PAGE) ? a_i : page_o;
  wire logic [7:0] next_prio = (op == OP_PUSH_LEVEL) ? {prio_o[5:0], level_i} :
    (op == OP_POP_LEVEL) ? {prio_o[1:0], prio_o[7:2]} :
    ((op == OP_POP_PSR) || (op == OP_INT_RET)) ? rb[SEL_PRIO] :
    (op == OP_LEGACY_ACK) ? {prio_o[5:0], LEGACY_LEVEL} : prio_o;
  wire logic next_priv = fin ? is_priv(op) : priv;
  wire logic next_busy = fin ? 1'b0 : (busy || go);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      n_clk <= CLK_OTHER;
      op <= OP_OTHER;
      take <= 1'b0;
    end else if (go) begin
      busy <= 1'b1;
      cnt <= 5'h01;
      n_clk <= clocks(op_i, next_take);
      op <= op_i;
      take <= next_take;
    end else begin
      busy <= next_busy;
      cnt <= busy ? cnt + 5'h01 : 5'h00;
    end
  end

  // Stack port: one byte per cycle from the second cycle after acceptance.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      cap <= 1'b0;
      cap_sel <= SEL_PCL;
      req_sel <= SEL_PCL;
    end else begin
      mem_req_o <= issue;
      mem_we_o <= issue && is_push(op);
      mem_addr_o <= issue ? next_addr : mem_addr_o;
      mem_wdata_o <= (issue && is_push(op)) ? next_wdata : 8'h00;
      cap <= mem_req_o && !mem_we_o;
      // Read data arrives one cycle after its request, so the byte select trails it by that cycle.
      req_sel <= issue ? sel : req_sel;
      cap_sel <= req_sel;
    end
  end

  always_ff @(posedge clock_i) begin
    if (cap) begin
      rb[cap_sel] <= mem_rdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o <= PC_RST;
      sp_o <= SP_RST;
      page_o <= PAGE_RST;
      prio_o <= PRIO_RST;
      b_o <= 8'h00;
      b_we_o <= 1'b0;
      b_alt_o <= 1'b0;
      flags_we_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      pc_o <= fin ? commit_pc(op, take) : pc_o;
      sp_o <= fin ? commit_sp(op, take) : sp_o;
      page_o <= fin ? next_page : page_o;
      prio_o <= fin ? next_prio : prio_o;
      b_o <= (fin && op == OP_DEC_BRANCH) ? b_dec : b_o;
      b_we_o <= fin && (op == OP_DEC_BRANCH);
      b_alt_o <= fin && (op == OP_DEC_BRANCH) && alt_i;
      flags_we_o <= fin && (op == OP_BIT_HL);
      done_o <= fin;
      illegal_o <= start_i && !busy && bad;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      priv <= 1'b0;
      busy_o <= 1'b0;
      int_ok_o <= 1'b1;
    end else begin
      priv <= next_priv;
      busy_o <= next_busy;
      int_ok_o <= !next_busy && !go && !next_priv;
    end
  end

  AST_CALL_SP: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_CALL |-> ##12 done_o && sp_o == $past(sp_o, 12) - 16'h0002)
    else $error("near call stack or timing wrong");
  AST_JR_PC: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_JR |-> ##5 done_o && pc_o == $past(next_pc_i, 5) + {{8{$past(disp_i[7], 5)}}, $past(disp_i, 5)})
    else $error("relative branch target or timing wrong");
  AST_FAR_CALL: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_FAR_CALL |-> ##19 done_o && sp_o == $past(sp_o, 19) - 16'h0003 && page_o == $past(page_i, 1))
    else $error("far call wrong");
  AST_FAR_RET: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_FAR_RET |-> ##13 done_o && sp_o == $past(sp_o, 13) + 16'h0003)
    else $error("far return wrong");
  AST_RET_SKIP: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_RET_F && !cond_i |-> ##1 !done_o ##1 done_o && sp_o == $past(sp_o, 2))
    else $error("untaken return wrong");
  AST_INT_RET: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_INT_RET |-> ##12 done_o && sp_o == $past(sp_o, 12) + 16'h0003)
    else $error("interrupt return wrong");
  AST_PUSH_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_PUSH_LEVEL |-> ##4 prio_o == {$past(prio_o[5:0], 4), $past(level_i, 4)})
    else $error("push level wrong");
  AST_POP_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_POP_LEVEL |-> ##4 prio_o == {$past(prio_o[1:0], 4), $past(prio_o[7:2], 4)})
    else $error("pop level wrong");
  AST_PSR_STACK: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_PUSH_PSR |-> ##2 mem_req_o && mem_we_o && mem_addr_o == sp_o - 16'h0001 ##7 done_o)
    else $error("priority push wrong");
  AST_LEGACY: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_LEGACY_ACK |-> ##10 done_o && sp_o == $past(sp_o, 10) - 16'h0002)
    else $error("legacy acknowledge wrong");
  AST_PRIV_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    done_o && priv |-> !int_ok_o throughout (done_o [*1] ##1 !done_o [*1]))
    else $error("interrupt allowed after privileged instruction");
  AST_SET_FLAGS: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_SET_BIT |-> ##10 done_o && !flags_we_o)
    else $error("bit set touched flags");
  AST_LD_SP_PRIV: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_LD_SP_HL |-> ##2 done_o && sp_o == $past(hl_i, 2) && !int_ok_o)
    else $error("stack pointer load wrong or interruptible");
  AST_BAD_RESTART: assert property (@(posedge clock_i) disable iff (rst_i)
    start_i && !busy && bad |=> illegal_o && !busy_o)
    else $error("refused restart was executed");
  AST_DEC_BRANCH: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_DEC_BRANCH |-> ##5 done_o && b_we_o && b_o == $past(b_i, 5) - 8'h01)
    else $error("decrement branch count wrong");
  AST_JP_INDEX: assert property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_JP_IX |-> ##6 done_o && pc_o == $past(ix_i, 6))
    else $error("indexed jump target or timing wrong");

  COV_CALL: cover property (@(posedge clock_i) disable iff (rst_i) go && op_i == OP_CALL ##12 done_o);
  COV_RET_TAKEN: cover property (@(posedge clock_i) disable iff (rst_i) go && op_i == OP_RET_F && cond_i);
  COV_PAGE_THEN_RETURN: cover property (@(posedge clock_i) disable iff (rst_i)
    go && op_i == OP_LD_PAGE ##4 go && op_i == OP_INT_RET);
  COV_ILLEGAL: cover property (@(posedge clock_i) disable iff (rst_i) illegal_o);
endmodule : control_flow_priority_exec

// [sim/tb_control_flow_priority_exec.sv]
module tb_control_flow_priority_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import control_flow_priority_pkg::*;
  typedef struct {
    op_t op; logic c; logic [7:0] arg; logic [4:0] clk; logic [15:0] pc; logic [15:0] sp;
    logic [7:0] prio; logic [7:0] page; logic [1:0] nw; logic [23:0] w0; logic ok;
  } row_t;
  logic clock_i, rst_i, start_i, cond_i, alt_i;
  op_t op_i;
  logic [15:0] next_pc_i, imm_i, hl_i, ix_i, iy_i, pc_o, sp_o, mem_addr_o;
  logic [7:0] disp_i, page_i, vec_i, ext_base_i, a_i, b_i, page_o, prio_o, b_o, mem_wdata_o;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [1:0] level_i;
  logic b_we_o, b_alt_o, flags_we_o, mem_req_o, mem_we_o, busy_o, done_o, illegal_o, int_ok_o;
  int num_errors, cmp_count;
  logic [7:0] mem [0:255];
  logic [23:0] wlog [$];
  logic rd_pend = 1'h0;
  logic seen_fw, seen_bwe, seen_balt;
  logic [7:0] rd_addr;
  logic [7:0] vecs [7] = '{8'h00, 8'h08, 8'h30, 8'h10, 8'h18, 8'h20, 8'h28};
  // Pc of ffff means the result address is not compared.
  row_t rows [34] = '{
    '{OP_LD_SP_HL,1'h0,8'h00,5'h02,16'hffff,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h0},
    '{OP_CALL,1'h0,8'h00,5'h0c,16'h0500,16'h803e,8'hff,8'h00,2'h2,24'h803f12,1'h1},
    '{OP_RET,1'h0,8'h00,5'h08,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JR,1'h0,8'hf0,5'h05,16'h1224,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JR,1'h0,8'h00,5'h05,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JR_CC,1'h0,8'h10,5'h05,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JR_CC,1'h1,8'h10,5'h05,16'h1244,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP_HL,1'h0,8'h00,5'h04,16'h8040,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP_IX,1'h0,8'h00,5'h06,16'h3000,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP_IY,1'h0,8'h00,5'h06,16'h4000,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP,1'h1,8'h00,5'h07,16'h0500,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP_F,1'h0,8'h00,5'h07,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_JP_F,1'h1,8'h00,5'h07,16'h0500,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_FAR_CALL,1'h0,8'h00,5'h13,16'h0500,16'h803d,8'hff,8'h45,2'h3,24'h803f00,1'h1},
    '{OP_FAR_RET,1'h0,8'h00,5'h0d,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_RET_F,1'h0,8'h00,5'h02,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_RESTART,1'h0,8'h00,5'h0a,16'h7010,16'h803e,8'hff,8'h00,2'h2,24'h803f12,1'h1},
    '{OP_RET_F,1'h1,8'h00,5'h08,16'h1234,16'h8040,8'hff,8'h00,2'h0,24'h0,1'h1},
    '{OP_FAR_JUMP,1'h0,8'h00,5'h0a,16'h0500,16'h8040,8'hff,8'h45,2'h0,24'h0,1'h1},
    '{OP_PUSH_LEVEL,1'h0,8'h00,5'h04,16'hffff,16'h8040,8'hfc,8'h45,2'h0,24'h0,1'h0},
    '{OP_PUSH_LEVEL,1'h0,8'h01,5'h04,16'hffff,16'h8040,8'hf1,8'h45,2'h0,24'h0,1'h0},
    '{OP_PUSH_LEVEL,1'h0,8'h02,5'h04,16'hffff,16'h8040,8'hc6,8'h45,2'h0,24'h0,1'h0},
    '{OP_PUSH_LEVEL,1'h0,8'h03,5'h04,16'hffff,16'h8040,8'h1b,8'h45,2'h0,24'h0,1'h0},
    '{OP_POP_LEVEL,1'h0,8'h00,5'h04,16'hffff,16'h8040,8'hc6,8'h45,2'h0,24'h0,1'h0},
    '{OP_PUSH_PSR,1'h0,8'h00,5'h09,16'hffff,16'h803f,8'hc6,8'h45,2'h1,24'h803fc6,1'h1},
    '{OP_POP_LEVEL,1'h0,8'h00,5'h04,16'hffff,16'h803f,8'hb1,8'h45,2'h0,24'h0,1'h0},
    '{OP_POP_PSR,1'h0,8'h00,5'h07,16'hffff,16'h8040,8'hc6,8'h45,2'h0,24'h0,1'h0},
    '{OP_LEGACY_ACK,1'h0,8'h00,5'h0a,16'hffff,16'h803e,8'h19,8'h45,2'h2,24'h803f12,1'h1},
    '{OP_LD_PAGE,1'h0,8'h00,5'h04,16'hffff,16'h803e,8'h19,8'h99,2'h0,24'h0,1'h0},
    '{OP_INT_RET,1'h0,8'h00,5'h0c,16'h2d12,16'h8041,8'h34,8'h99,2'h0,24'h0,1'h1},
    '{OP_BIT_HL,1'h0,8'h00,5'h07,16'hffff,16'h8041,8'h34,8'h99,2'h0,24'h0,1'h0},
    '{OP_SET_BIT,1'h0,8'h00,5'h0a,16'hffff,16'h8041,8'h34,8'h99,2'h0,24'h0,1'h1},
    '{OP_LD_SP_IX,1'h0,8'h00,5'h02,16'hffff,16'h3000,8'h34,8'h99,2'h0,24'h0,1'h0},
    '{OP_LD_SP_IY,1'h0,8'h00,5'h02,16'hffff,16'h4000,8'h34,8'h99,2'h0,24'h0,1'h0}};

  control_flow_priority_exec u_control_flow_priority_exec (.clock_i, .rst_i, .start_i, .op_i, .cond_i,
    .next_pc_i, .imm_i, .disp_i, .page_i, .level_i, .vec_i, .ext_base_i, .hl_i, .ix_i, .iy_i, .a_i, .b_i,
    .alt_i, .mem_rdata_i, .pc_o, .sp_o, .page_o, .prio_o, .b_o, .b_we_o, .b_alt_o, .flags_we_o, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .busy_o, .done_o, .illegal_o, .int_ok_o);

  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  // Stack memory: writes land at the request edge, reads answer one cycle after the request.
  always @(posedge clock_i) begin
    rd_pend <= (mem_req_o === 1'h1) && (mem_we_o === 1'h0);
    rd_addr <= mem_addr_o[7:0];
    // A known byte above the stack top gives the interrupt return a fixed high byte.
    if (rst_i === 1'h1) begin
      mem[8'h40] <= 8'h2d;
    end
    if ((mem_req_o === 1'h1) && (mem_we_o === 1'h1)) begin
      mem[mem_addr_o[7:0]] <= mem_wdata_o;
      wlog.push_back({mem_addr_o, mem_wdata_o});
    end
  end
  // Outside a read answer the data lines toggle so stale data cannot pass.
  always @(negedge clock_i) mem_rdata_i <= rd_pend ? mem[rd_addr] : ~mem_rdata_i;

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Entered at a falling edge; returns one idle cycle after completion.
  task automatic run_op(input row_t r);
    int k;
    op_i = r.op;
    cond_i = r.c;
    disp_i = r.arg;
    level_i = r.arg[1:0];
    start_i = 1'h1;
    wlog.delete();
    @(posedge clock_i);
    for (k = 1; k <= 40; k++) begin
      @(negedge clock_i);
      start_i = 1'h0;
      if (done_o === 1'h1) break;
    end
    if (k > 40) begin
      num_errors++;
      give_verdict();
    end
    seen_fw = flags_we_o;
    seen_bwe = b_we_o;
    seen_balt = b_alt_o;
    chk("clocks", 24'(r.clk), 24'(k));
    if (r.pc !== 16'hffff) chk("pc", 24'(r.pc), 24'(pc_o));
    chk("sp", 24'(r.sp), 24'(sp_o));
    chk("prio", 24'(r.prio), 24'(prio_o));
    chk("page", 24'(r.page), 24'(page_o));
    chk("writes", 24'(r.nw), 24'(wlog.size()));
    if (r.nw != 2'h0) chk("first write", r.w0, wlog[0]);
    chk("flags strobe", 24'(r.op == OP_BIT_HL), 24'(seen_fw));
    @(negedge clock_i);
    chk("int ok", 24'(r.ok), 24'(int_ok_o));
  endtask : run_op

  initial begin
    int i;
    rst_i = 1'h1;
    start_i = 1'h0;
    op_i = OP_OTHER;
    {cond_i, alt_i, level_i} = 4'h0;
    {next_pc_i, imm_i, hl_i, ix_i, iy_i} = {16'h1234, 16'h0500, 16'h8040, 16'h3000, 16'h4000};
    {disp_i, page_i, vec_i, ext_base_i, a_i, b_i} = 48'h00_45_10_70_99_02;
    repeat (12) @(negedge clock_i);
    chk("reset", 24'h00ff01, {pc_o[7:0], prio_o, 7'h00, int_ok_o});
    rst_i = 1'h0;
    foreach (rows[j]) run_op(rows[j]);
    // Refused restart vectors, then accepted vectors 10h to 28h, each followed by a return.
    for (i = 0; i < 7; i++) begin
      vec_i = vecs[i];
      if (i < 3) begin
        op_i = OP_RESTART;
        start_i = 1'h1;
        @(posedge clock_i);
        @(negedge clock_i);
        start_i = 1'h0;
        chk("refused", 24'h000100, {7'h00, illegal_o, 7'h00, busy_o});
        @(negedge clock_i);
        chk("sp kept", 24'h004000, 24'(sp_o));
      end else begin
        run_op('{OP_RESTART,1'h0,8'h00,5'h0a,{8'h70,vec_i},16'h3ffe,8'h34,8'h99,2'h2,24'h3fff12,1'h1});
        run_op('{OP_RET,1'h0,8'h00,5'h08,16'h1234,16'h4000,8'h34,8'h99,2'h0,24'h0,1'h1});
      end
    end
    for (i = 1; i < 3; i++) begin
      b_i = 8'(i);
      alt_i = i[1];
      run_op('{OP_DEC_BRANCH,1'h0,8'h08,5'h05,(i == 1) ? 16'h1234 : 16'h123c,16'h4000,8'h34,8'h99,2'h0,24'h0,1'h1});
      chk("b", 24'(i - 1), 24'(b_o));
      chk("b strobes", {23'h000001, i[1]}, {22'h000000, seen_bwe, seen_balt});
    end
    // Reset in the middle of a call abandons it.
    op_i = OP_CALL;
    start_i = 1'h1;
    @(negedge clock_i);
    start_i = 1'h0;
    repeat (3) @(negedge clock_i);
    rst_i = 1'h1;
    @(negedge clock_i);
    chk("mid reset", 24'h0ff400, {sp_o[3:0], prio_o, busy_o, int_ok_o, mem_req_o, 9'h000});
    rst_i = 1'h0;
    run_op('{OP_OTHER,1'h0,8'h00,5'h02,16'hffff,16'h0000,8'hff,8'h00,2'h0,24'h0,1'h1});
    give_verdict();
  end
endmodule : tb_control_flow_priority_exec
